// ==== verilog/adcsq_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes: AHB-Lite register slave with one 32-bit aligned word per register.
// Notes: Definitions only.
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADCSQ_CTRL_OFS 12'h000
`define ADCSQ_CFG_OFS 12'h004
`define ADCSQ_RESH_OFS 12'h008
`define ADCSQ_RESL_OFS 12'h00c
`define ADCSQ_STAT_OFS 12'h010
`define ADCSQ_PORT_OFS 12'h014
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCSQ_CTRL_ON_BIT 0
`define ADCSQ_CTRL_GO_BIT 2
`define ADCSQ_CTRL_CHS_LSB 3
`define ADCSQ_CTRL_CS_LSB 6
`define ADCSQ_CFG_PCFG_LSB 0
`define ADCSQ_CFG_CS2_BIT 6
`define ADCSQ_CFG_JUST_BIT 7
`define ADCSQ_STAT_DONE_BIT 0
`define ADCSQ_STAT_BUSY_BIT 1
// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define ADCSQ_CTRL_RST 8'h00
`define ADCSQ_CFG_RST 8'h00
`define ADCSQ_CONV_TADS 4'hc
`define ADCSQ_WAIT_TADS 4'h2
`define ADCSQ_CLEAR_DONE 32'h0000_0001
`endif

// ==== verilog/adcsq_pkg.sv ====
// Purpose: Types of the converter sequencer.
// Assumes: Constants live in adcsq_map.svh.
// Notes: One-hot sequencer states.
package adcsq_pkg;
  typedef enum logic [3:0] {
    ADCSQ_IDLE = 4'b0001,
    ADCSQ_CONV = 4'b0010,
    ADCSQ_WAIT = 4'b0100,
    ADCSQ_ACQ = 4'b1000
  } adcsq_state_t;
endpackage

// ==== verilog/adcsq_prescale.sv ====
// Purpose: Bit-period enable generator for the converter.
// Assumes: One core clock; RC source arrives as a synchronous tick input.
// Notes: Restarts on demand so a divided bit period always begins whole; the RC tick passes straight through.
`timescale 1ns/100ps
`default_nettype none
module adcsq_prescale
  import adcsq_pkg::*;
#(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic [2:0] i_sel,
  input wire logic i_restart,
  input wire logic i_rc_tick,
  // Output
  output logic o_tick
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [2:0] sel;
  } adcsq_pre_t;
  adcsq_pre_t st;
  adcsq_pre_t next_st;
  logic [CNT_W-1:0] limit;
  if (CNT_W < 6) begin : g_bad_width
    $error("adcsq_prescale needs at least 6 counter bits");
  end
  always_comb begin
    case (i_sel)
      3'h0: limit = CNT_W'(1);
      3'h4: limit = CNT_W'(3);
      3'h1: limit = CNT_W'(7);
      3'h5: limit = CNT_W'(15);
      3'h2: limit = CNT_W'(31);
      3'h6: limit = CNT_W'(63);
      default: limit = '0;
    endcase
  end
  // Changing the selection mid-period restarts the count.
  wire logic restart = i_restart || (i_sel != st.sel);
  always_comb begin
    next_st = st;
    next_st.sel = i_sel;
    if (restart || st.cnt == limit) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_tick = (i_sel == 3'h3) ? i_rc_tick : (!restart && st.cnt == limit);
  a_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_tick && i_sel == 3'h0 && $stable(i_sel) && !i_restart) ##1
    (!i_restart && i_sel == 3'h0) |-> !o_tick)
    else $error("two-period tick repeated too soon");
endmodule
`default_nettype wire

// ==== verilog/adcsq_top.sv ====
// Purpose: Converter sequencer: bit-period clocking, conversion, abort, result and trigger.
// Assumes: AHB-Lite single word transfers; SAR core supplies the 10-bit sample at the end.
// Notes: Zero wait-state slave; result registers are plain storage while the converter is off.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_map.svh"
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int PIN_N = 8
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [11:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Converter core
  input wire logic [9:0] I_SAR_RESULT,
  input wire logic I_RC_TICK,
  output logic O_SAMPLE_EN,
  output logic O_CONV_ACTIVE,
  output logic [2:0] O_CHANNEL_SELECT,
  // Port pins and trigger
  input wire logic [PIN_N-1:0] I_PIN_LEVEL,
  input wire logic [PIN_N-1:0] I_PIN_IS_ANALOG,
  input wire logic [3:0] I_ENH_CAPTURE_MODE_FIELD,
  input wire logic I_SPECIAL_EVENT,
  output logic O_TIMER_CLEAR,
  // Status
  output logic O_CONV_DONE_FLAG
);
  if (PIN_N < 1 || PIN_N > 32) begin : g_bad_pins
    $error("adcsq_top supports 1 to 32 port pins");
  end
  typedef struct packed {
    adcsq_state_t state;
    logic [3:0] tads;
    logic converter_on;
    logic go;
    logic [2:0] channel_select;
    logic [2:0] conv_clock_select;
    logic result_justify_select;
    logic [3:0] pcfg;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic conv_done_flag;
    logic dph_write;
    logic [11:0] dph_addr;
    logic [31:0] rdata;
    logic timer_clear;
  } adcsq_top_t;
  adcsq_top_t st;
  adcsq_top_t next_st;
  logic tick;
  logic pre_restart;
  logic [15:0] just;
  logic [31:0] port_rd;
  logic [31:0] rd_mux;
  logic [PIN_N-1:0] port_bits;
  // --------------------------------------------------------------------------
  // Bit-period prescaler
  // --------------------------------------------------------------------------
  adcsq_prescale #(.CNT_W(6)) u_pre (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_sel(st.conv_clock_select),
    .i_restart(pre_restart),
    .i_rc_tick(I_RC_TICK),
    .o_tick(tick)
  );
  // --------------------------------------------------------------------------
  // Port read-back and justification
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      assign port_bits[g] = I_PIN_IS_ANALOG[g] ? 1'b0 : I_PIN_LEVEL[g];
    end
  endgenerate
  assign port_rd = 32'(port_bits);
  assign just = st.result_justify_select ? {6'h00, I_SAR_RESULT} : {I_SAR_RESULT, 6'h00};
  wire logic addr_ph = I_HSEL && I_HREADY && I_HTRANS[1];
  wire logic wr_ctrl = st.dph_write && st.dph_addr == `ADCSQ_CTRL_OFS;
  wire logic sw_go_set = wr_ctrl && I_HWDATA[`ADCSQ_CTRL_GO_BIT];
  wire logic trig_hit = I_SPECIAL_EVENT && I_ENH_CAPTURE_MODE_FIELD == 4'hb;
  wire logic conv_end = st.state == ADCSQ_CONV && tick && st.tads == `ADCSQ_CONV_TADS - 4'h1;
  // --------------------------------------------------------------------------
  // Sequencer and registers
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.dph_write = addr_ph && I_HWRITE;
    next_st.dph_addr = addr_ph ? I_HADDR : 12'h0;
    rd_mux = 32'h0;
    next_st.timer_clear = trig_hit;
    pre_restart = 1'b0;
    if (st.dph_write) begin
      case (st.dph_addr)
        `ADCSQ_CTRL_OFS: begin
          next_st.converter_on = I_HWDATA[`ADCSQ_CTRL_ON_BIT];
          next_st.go = I_HWDATA[`ADCSQ_CTRL_GO_BIT];
          next_st.channel_select = I_HWDATA[`ADCSQ_CTRL_CHS_LSB +: 3];
          next_st.conv_clock_select[1:0] = I_HWDATA[`ADCSQ_CTRL_CS_LSB +: 2];
        end
        `ADCSQ_CFG_OFS: begin
          next_st.pcfg = I_HWDATA[`ADCSQ_CFG_PCFG_LSB +: 4];
          next_st.conv_clock_select[2] = I_HWDATA[`ADCSQ_CFG_CS2_BIT];
          next_st.result_justify_select = I_HWDATA[`ADCSQ_CFG_JUST_BIT];
        end
        `ADCSQ_RESH_OFS: next_st.result_high_byte = I_HWDATA[7:0];
        `ADCSQ_RESL_OFS: next_st.result_low_byte = I_HWDATA[7:0];
        `ADCSQ_STAT_OFS: begin
          if (I_HWDATA[`ADCSQ_STAT_DONE_BIT]) next_st.conv_done_flag = 1'b0;
        end
        default: next_st.conv_done_flag = st.conv_done_flag;
      endcase
    end
    if (!next_st.converter_on) next_st.go = 1'b0;
    if (trig_hit && next_st.converter_on) next_st.go = 1'b1;
    case (st.state)
      ADCSQ_IDLE, ADCSQ_ACQ: begin
        if (next_st.go && st.converter_on) begin
          next_st.state = ADCSQ_CONV;
          next_st.tads = 4'h0;
          pre_restart = 1'b1;
        end else if (st.state == ADCSQ_ACQ && !next_st.converter_on) begin
          next_st.state = ADCSQ_IDLE;
        end
      end
      ADCSQ_CONV: begin
        if (!next_st.go) begin
          next_st.state = ADCSQ_WAIT;
          next_st.tads = 4'h0;
          pre_restart = 1'b1;
        end else if (tick) begin
          next_st.tads = st.tads + 4'h1;
          if (conv_end) begin
            next_st.result_high_byte = just[15:8];
            next_st.result_low_byte = just[7:0];
            next_st.go = 1'b0;
            next_st.state = ADCSQ_WAIT;
            next_st.tads = 4'h0;
          end
        end
      end
      ADCSQ_WAIT: begin
        if (tick) begin
          next_st.tads = st.tads + 4'h1;
          if (st.tads == `ADCSQ_WAIT_TADS - 4'h1) begin
            next_st.state = ADCSQ_ACQ;
            next_st.tads = 4'h0;
          end
        end
      end
      default: next_st.state = ADCSQ_IDLE;
    endcase
    // Completion sets the flag after any clear in the same cycle.
    if (conv_end && next_st.go == 1'b0 && st.go) next_st.conv_done_flag = 1'b1;
    // Read data is taken at the address phase from the values this edge commits,
    // so it stands through the data phase and a read behind a write sees the write.
    case (I_HADDR)
      `ADCSQ_CTRL_OFS: begin
        rd_mux = {24'h0, next_st.conv_clock_select[1:0], next_st.channel_select,
                  next_st.go, 1'b0, next_st.converter_on};
      end
      `ADCSQ_CFG_OFS: begin
        rd_mux = {24'h0, next_st.result_justify_select, next_st.conv_clock_select[2],
                  2'b00, next_st.pcfg};
      end
      `ADCSQ_RESH_OFS: rd_mux = {24'h0, next_st.result_high_byte};
      `ADCSQ_RESL_OFS: rd_mux = {24'h0, next_st.result_low_byte};
      `ADCSQ_STAT_OFS: rd_mux = {30'h0, next_st.state != ADCSQ_IDLE, next_st.conv_done_flag};
      `ADCSQ_PORT_OFS: rd_mux = port_rd;
      default: rd_mux = 32'h0;
    endcase
    if (addr_ph && !I_HWRITE) next_st.rdata = rd_mux;
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      // Result bytes clear too: stale data never leaks out of reset.
      st <= '0;
      st.state <= ADCSQ_IDLE;
    end else begin
      st <= next_st;
    end
  end
  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = st.rdata;
  assign O_SAMPLE_EN = st.state == ADCSQ_ACQ;
  assign O_CONV_ACTIVE = st.state == ADCSQ_CONV;
  assign O_CHANNEL_SELECT = st.channel_select;
  assign O_TIMER_CLEAR = st.timer_clear;
  assign O_CONV_DONE_FLAG = st.conv_done_flag;
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_abort_keeps: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.state == ADCSQ_CONV && !conv_end && next_st.state == ADCSQ_WAIT) |=>
    $stable(st.result_high_byte) && $stable(st.result_low_byte))
    else $error("abort changed the result");
  a_done_clears: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    conv_end |=> !st.go && st.conv_done_flag && st.state == ADCSQ_WAIT)
    else $error("completion did not clear go and set the flag");
  a_trig_timer: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    trig_hit |=> O_TIMER_CLEAR)
    else $error("trigger did not clear the timer");
  a_trig_off: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (trig_hit && !st.converter_on && !st.dph_write) |=> !st.go)
    else $error("trigger started a disabled converter");
  a_trig_on: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (trig_hit && st.converter_on && !st.dph_write) |=> st.go)
    else $error("trigger failed to set go");
  a_abort_wait: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.state == ADCSQ_CONV && !next_st.go) |=> st.state == ADCSQ_WAIT && st.tads == 4'h0)
    else $error("abort did not enter the wait");
  a_wait_len: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.state == ADCSQ_WAIT && tick && st.tads == 4'h1) |=> st.state == ADCSQ_ACQ)
    else $error("wait did not end after two bit periods");
  a_conv_len: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.state == ADCSQ_CONV && $past(st.state) != ADCSQ_CONV) |-> st.tads == 4'h0)
    else $error("conversion did not start at bit zero");
  a_port_zero: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (port_rd[PIN_N-1:0] & I_PIN_IS_ANALOG) == '0)
    else $error("analogue pin read as one");
  a_right_just: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (conv_end && st.result_justify_select) |=> st.result_high_byte[7:2] == 6'h00)
    else $error("right justify left upper bits set");
  a_left_just: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (conv_end && !st.result_justify_select) |=> st.result_low_byte[5:0] == 6'h00)
    else $error("left justify left lower bits set");
  a_result_load: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    conv_end |=> {st.result_high_byte, st.result_low_byte} == $past(just))
    else $error("completion did not load the sample");
  // Reset itself is the trigger here, so this one has no disable clause.
  a_reset_idle: assert property (@(posedge I_CORE_CLK)
    I_SYS_RST |=> st.state == ADCSQ_IDLE && !st.converter_on && !st.go)
    else $error("reset did not stop the converter");
  a_off_no_go: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    !st.converter_on |-> !st.go)
    else $error("go set while converter off");
  a_conv_bound: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    st.state == ADCSQ_CONV |-> st.tads < `ADCSQ_CONV_TADS)
    else $error("conversion ran past twelve bit periods");
  a_sw_go: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (sw_go_set && wr_ctrl && I_HWDATA[`ADCSQ_CTRL_ON_BIT] && st.converter_on &&
     (st.state == ADCSQ_IDLE || st.state == ADCSQ_ACQ)) |=> st.state == ADCSQ_CONV)
    else $error("software go did not start a conversion");
  a_holdoff_src: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    $rose(O_SAMPLE_EN) |-> $past(st.state) == ADCSQ_WAIT)
    else $error("acquisition started without the wait");
  a_timer_pulse: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    O_TIMER_CLEAR |-> $past(trig_hit))
    else $error("timer clear without a trigger");
  a_res_write: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.dph_write && st.dph_addr == `ADCSQ_RESH_OFS && st.state != ADCSQ_CONV) |=>
    st.result_high_byte == $past(I_HWDATA[7:0]))
    else $error("result byte write lost");
  a_done_sticky: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.conv_done_flag && !(st.dph_write && st.dph_addr == `ADCSQ_STAT_OFS)) |=>
    st.conv_done_flag)
    else $error("done flag dropped without a clear");
  a_abort_no_flag: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st.state == ADCSQ_CONV && !conv_end && next_st.state == ADCSQ_WAIT &&
     !st.conv_done_flag) |=> !st.conv_done_flag)
    else $error("abort set the done flag");
endmodule
`default_nettype wire

// ==== tb/adcsq_sar_model.sv ====
// Purpose: Stand-in for the converter core: sample source and free RC tick.
// Assumes: The RC oscillator runs free; ticks are one core cycle wide.
// Notes: Outside a conversion the result lines carry a toggling pattern.
`timescale 1ns/100ps
`default_nettype none
module adcsq_sar_model #(
  parameter int RC_DIV = 5
) (
  // Clock
  input wire logic i_clk,
  // Core side
  input wire logic i_conv,
  input wire logic [9:0] i_sample,
  output logic [9:0] o_result,
  output logic o_rc_tick
);
  int cnt = 0;
  logic [9:0] junk = 10'h155;
  always @(posedge i_clk) begin
    cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
    junk <= ~junk;
  end
  assign o_rc_tick = (cnt == RC_DIV - 1);
  // A stale sample must never look valid, so junk shows outside conversions.
  assign o_result = i_conv ? i_sample : junk;
endmodule
`default_nettype wire

// ==== tb/adc_sequencer_clock_trigger_bench.sv ====
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: Zero wait-state bus slave; RC ticks come from the core stand-in.
// Notes: Samples, pins and justify choice are seeded random.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_map.svh"
module adc_sequencer_clock_trigger_bench
  import adcsq_pkg::*;
;
  // The RC run uses a 4 us bit period, the one setting here that meets the minimum.
  localparam int RC = 400;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, spec = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, v;
  logic [9:0] sample = 10'h000, sar;
  logic [7:0] pins = 8'h00, ana = 8'h00;
  logic [3:0] mode = 4'h0;
  logic [2:0] chan;
  logic [15:0] e;
  logic hready, hresp, samp, conv, tclr, flag, rc_tick, on;
  logic [2:0] sel_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int per_tab [7] = '{2, 4, 8, 16, 32, 64, RC};
  int seed = 17413, n, p, nt, nc, n_errors = 0, cmp_count = 0;
  always #5 clk = ~clk;
  adcsq_top #(.PIN_N(8)) i_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .I_SAR_RESULT(sar), .I_RC_TICK(rc_tick), .O_SAMPLE_EN(samp),
    .O_CONV_ACTIVE(conv), .O_CHANNEL_SELECT(chan), .I_PIN_LEVEL(pins),
    .I_PIN_IS_ANALOG(ana), .I_ENH_CAPTURE_MODE_FIELD(mode), .I_SPECIAL_EVENT(spec),
    .O_TIMER_CLEAR(tclr), .O_CONV_DONE_FLAG(flag));
  adcsq_sar_model #(.RC_DIV(RC)) i_core (.i_clk(clk), .i_conv(conv), .i_sample(sample),
    .o_result(sar), .o_rc_tick(rc_tick));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic rng(input string nm, input int g, input int lo, input int hi);
    cmp_count++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, x, r);
  endtask
  task automatic conv_len(output int c);
    int w;
    w = 0;
    c = 0;
    while (conv !== 1'b1 && w < 300) begin @(posedge clk); w++; end
    while (conv === 1'b1 && c < 6000) begin @(posedge clk); c++; end
  endtask
  task automatic acq_wait(output int c);
    c = 0;
    while (samp !== 1'b1 && c < 1000) begin @(posedge clk); c++; end
  endtask
  function automatic logic [15:0] just(input logic [9:0] s, input logic r);
    return r ? {6'h00, s} : {s, 6'h00};
  endfunction
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl", `ADCSQ_CTRL_OFS, 32'h0);
    rdc("cfg", `ADCSQ_CFG_OFS, 32'h0);
    rdc("stat", `ADCSQ_STAT_OFS, 32'h0);
    rdc("unmapped", 12'h03c, 32'h0);
    v = $random(seed);
    wr(`ADCSQ_RESH_OFS, {24'h0, v[7:0]});
    wr(`ADCSQ_RESL_OFS, {24'h0, v[15:8]});
    rdc("res_high", `ADCSQ_RESH_OFS, {24'h0, v[7:0]});
    rdc("res_low", `ADCSQ_RESL_OFS, {24'h0, v[15:8]});
    pins <= v[23:16];
    ana <= v[31:24];
    rdc("port", `ADCSQ_PORT_OFS, {24'h0, v[23:16] & ~v[31:24]});
    for (int i = 0; i < 7; i++) begin
      v = $random(seed);
      p = per_tab[i];
      sample <= v[9:0];
      wr(`ADCSQ_CFG_OFS, {24'h0, v[10], sel_tab[i][2], 6'h00});
      // Switch on first and start in a later write.
      wr(`ADCSQ_CTRL_OFS, {24'h0, sel_tab[i][1:0], v[13:11], 3'h1});
      @(posedge clk);
      chk("channel", {29'h0, v[13:11]}, {29'h0, chan});
      wr(`ADCSQ_CTRL_OFS, {24'h0, sel_tab[i][1:0], v[13:11], 3'h5});
      conv_len(n);
      rng("conv_cycles", n, (i == 6) ? 11 * p : 12 * p - 1, 12 * p + 1);
      acq_wait(n);
      rng("holdoff", n, (i == 6) ? p : 2 * p - 1, 2 * p + 1);
      e = just(v[9:0], v[10]);
      rdc("res_high", `ADCSQ_RESH_OFS, {24'h0, e[15:8]});
      rdc("res_low", `ADCSQ_RESL_OFS, {24'h0, e[7:0]});
      rdc("stat", `ADCSQ_STAT_OFS, 32'h3);
      rdc("ctrl", `ADCSQ_CTRL_OFS, {24'h0, sel_tab[i][1:0], v[13:11], 3'h1});
      chk("done_flag", 32'h1, {31'h0, flag});
      wr(`ADCSQ_STAT_OFS, `ADCSQ_CLEAR_DONE);
    end
    wr(`ADCSQ_CFG_OFS, 32'h0);
    wr(`ADCSQ_CTRL_OFS, 32'h55);
    repeat (20 + v[4:0]) @(posedge clk);
    wr(`ADCSQ_CTRL_OFS, 32'h51);
    repeat (2) @(posedge clk);
    chk("abort_conv", 32'h0, {31'h0, conv});
    acq_wait(n);
    rng("abort_wait", n, 6, 16);
    chk("abort_flag", 32'h0, {31'h0, flag});
    rdc("res_high", `ADCSQ_RESH_OFS, {24'h0, e[15:8]});
    rdc("res_low", `ADCSQ_RESL_OFS, {24'h0, e[7:0]});
    for (int m = 0; m < 18; m++) begin
      v = $random(seed);
      // Two extra passes give the trigger mode with the converter both off and on.
      on = (m >= 16) ? m[0] : v[0];
      // Channel is chosen before any trigger can fire.
      wr(`ADCSQ_CTRL_OFS, {24'h0, 2'h0, 3'h2, 2'h0, on});
      mode <= (m >= 16) ? 4'hb : m[3:0];
      @(posedge clk);
      spec <= 1'b1;
      @(posedge clk);
      spec <= 1'b0;
      nt = 0;
      nc = 0;
      repeat (6) begin
        @(posedge clk);
        nt += (tclr === 1'b1);
        nc |= (conv === 1'b1);
      end
      chk("timer_clear", (m == 11 || m >= 16), nt);
      chk("trig_start", (m == 11 || m >= 16) && on, nc);
      if (nc) conv_len(n);
      wr(`ADCSQ_STAT_OFS, `ADCSQ_CLEAR_DONE);
    end
    wr(`ADCSQ_CTRL_OFS, 32'h55);
    repeat (10) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset_conv", 32'h0, {31'h0, conv});
    rdc("reset_ctrl", `ADCSQ_CTRL_OFS, 32'h0);
    results();
  end
endmodule
`default_nettype wire
